// >>> design/fiocp_bus_cycle.sv
// single asynchronous write or read cycle on the flash pins
`timescale 1ns/100ps
module fiocp_bus_cycle (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [fiocp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fiocp_pkg::DATA_W-1:0] data_i,
  output logic done_o,
  output logic [fiocp_pkg::DATA_W-1:0] rdata_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [fiocp_pkg::ADDR_W-1:0] addr_o,
  output logic [fiocp_pkg::DATA_W-1:0] dq_o,
  output logic [fiocp_pkg::DATA_W-1:0] dq_oe_o,
  input wire logic [fiocp_pkg::DATA_W-1:0] dq_i
);
  import fiocp_pkg::*;

  typedef enum logic [2:0] {PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD, PH_READ, PH_END} fiocp_phase_t;

  fiocp_phase_t phase, next_phase;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_done, next_ce_n, next_we_n, next_oe_n;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dq, next_dq_oe, next_rdata;
  logic [DATA_W-1:0] dq_meta, dq_sync;

  // ========================================================================
  // data pin synchroniser
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_meta <= '0;
      dq_sync <= '0;
    end else begin
      dq_meta <= dq_i;
      dq_sync <= dq_meta;
    end
  end

  // ========================================================================
  // cycle sequencing
  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_done = 1'b0;
    next_ce_n = ce_n_o;
    next_we_n = we_n_o;
    next_oe_n = oe_n_o;
    next_addr = addr_o;
    next_dq = dq_o;
    next_dq_oe = dq_oe_o;
    next_rdata = rdata_o;
    unique case (phase)
      PH_IDLE: begin
        if (start_i) begin
          next_addr = addr_i;
          next_ce_n = 1'b0;
          next_cnt = '0;
          if (write_i) begin
            next_dq = data_i;
            next_dq_oe = '1;
            next_phase = PH_SETUP;
          end else begin
            next_oe_n = 1'b0; // strobe is high here
            next_phase = PH_READ;
          end
        end
      end
      PH_SETUP: begin
        next_we_n = 1'b0; // select already low
        next_phase = PH_PULSE;
      end
      PH_PULSE: begin
        if (cnt == CNT_W'(WE_PULSE_CYC - 1)) begin
          next_we_n = 1'b1; // strobe rises first and captures
          next_phase = PH_HOLD;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      PH_HOLD: begin
        next_ce_n = 1'b1;
        next_phase = PH_END;
      end
      PH_READ: begin
        if (cnt == CNT_W'(ACCESS_CYC + SYNC_CYC - 1)) begin
          next_rdata = dq_sync;
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_done = 1'b1;
          next_phase = PH_IDLE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      PH_END: begin
        next_dq_oe = '0;
        next_done = 1'b1;
        next_phase = PH_IDLE;
      end
    endcase
  end

  // registers of the cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= PH_IDLE;
      cnt <= '0;
      done_o <= 1'b0;
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= '0;
      rdata_o <= '0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      done_o <= next_done;
      ce_n_o <= next_ce_n;
      we_n_o <= next_we_n;
      oe_n_o <= next_oe_n;
      addr_o <= next_addr;
      dq_o <= next_dq;
      dq_oe_o <= next_dq_oe;
      rdata_o <= next_rdata;
    end
  end

  // ========================================================================
  // pin checks
  we_oe_excl_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(!we_n_o && !oe_n_o)) else $error("strobe and output enable low together");
  write_select_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !we_n_o |-> !ce_n_o && (dq_oe_o == '1)) else $error("write strobe without select");
  strobe_first_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(we_n_o) |-> !ce_n_o ##1 ce_n_o) else $error("select rose before strobe");
  pulse_width_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(we_n_o) |-> !we_n_o [*5] ##1 we_n_o) else $error("write pulse width wrong");
  read_ends_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(oe_n_o) |-> ##[11:11] (done_o && oe_n_o)) else $error("read cycle length wrong");

endmodule // fiocp_bus_cycle

// >>> design/fiocp_host.sv
// host sequencer for identifier reads, otp program and lock, and array commands
`timescale 1ns/100ps
module fiocp_host (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire fiocp_pkg::fiocp_op_t op_i,
  input wire logic [fiocp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fiocp_pkg::DATA_W-1:0] data_i,
  input wire logic [7:0] cmd_i,
  input wire logic supply_ok_i,
  output logic ready_o,
  output logic done_o,
  output logic refused_o,
  output logic [fiocp_pkg::DATA_W-1:0] result_o,
  output logic [7:0] status_o,
  output logic prog_fail_o,
  output logic protect_o,
  output logic factory_unlocked_o,
  output logic customer_unlocked_o,
  output logic rp_n_o,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [fiocp_pkg::ADDR_W-1:0] addr_o,
  output logic [fiocp_pkg::DATA_W-1:0] dq_o,
  output logic [fiocp_pkg::DATA_W-1:0] dq_oe_o,
  input wire logic [fiocp_pkg::DATA_W-1:0] dq_i
);
  import fiocp_pkg::*;

  typedef enum logic [2:0] {
    ST_RESET, ST_WAKE, ST_IDLE, ST_FIRST, ST_SECOND, ST_POLL_CMD, ST_POLL, ST_FINISH
  } fiocp_state_t;

  // ========================================================================
  // helpers
  function automatic logic is_modify(input fiocp_op_t op);
    return op inside {OP_OTP_PROGRAM, OP_OTP_LOCK, OP_WORD_WRITE, OP_BLOCK_ERASE, OP_TWO_CYCLE};
  endfunction

  function automatic logic [7:0] first_code(input fiocp_op_t op, input logic [7:0] cmd);
    unique case (op)
      OP_READ_ARRAY: return CMD_READ_ARRAY;
      OP_READ_ID, OP_READ_BLOCK_LOCK: return CMD_READ_ID;
      OP_READ_STATUS: return CMD_READ_STATUS;
      OP_CLEAR_STATUS: return CMD_CLEAR_STATUS;
      OP_OTP_PROGRAM, OP_OTP_LOCK: return CMD_OTP_PROGRAM;
      OP_WORD_WRITE: return CMD_WORD_WRITE;
      OP_BLOCK_ERASE: return CMD_BLOCK_ERASE;
      default: return cmd;
    endcase
  endfunction

  // lock code word of the block holding an address: main blocks are 32K words
  function automatic logic [ADDR_W-1:0] block_lock_addr(input logic [ADDR_W-1:0] a);
    if (a[18:15] != 4'h0) begin
      return {a[18:15], 15'h0000} + BLOCK_LOCK_DISP;
    end
    return {a[18:12], 12'h000} + BLOCK_LOCK_DISP;
  endfunction

  fiocp_state_t state, next_state;
  fiocp_op_t op, next_op;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] data, next_data, next_result;
  logic [7:0] cmd, next_cmd, next_status;
  logic launched, next_launched;
  logic next_ready, next_done, next_refused, next_prog_fail, next_protect;
  logic next_factory, next_customer, next_rp_n;
  logic supply_meta, supply_ok;
  logic cyc_start, cyc_write, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_data, cyc_rdata;
  logic [7:0] last_code;

  // ========================================================================
  // pin cycle engine
  fiocp_bus_cycle u_cycle (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(cyc_start),
    .write_i(cyc_write),
    .addr_i(cyc_addr),
    .data_i(cyc_data),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .ce_n_o(ce_n_o),
    .we_n_o(we_n_o),
    .oe_n_o(oe_n_o),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe_o),
    .dq_i(dq_i)
  );

  // supply valid pin synchroniser
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_meta <= 1'b0;
      supply_ok <= 1'b0;
    end else begin
      supply_meta <= supply_ok_i;
      supply_ok <= supply_meta;
    end
  end

  // ========================================================================
  // operation sequencer
  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_addr = addr;
    next_data = data;
    next_cmd = cmd;
    next_launched = launched;
    next_ready = ready_o;
    next_done = 1'b0;
    next_refused = refused_o;
    next_result = result_o;
    next_status = status_o;
    next_prog_fail = prog_fail_o;
    next_protect = protect_o;
    next_factory = factory_unlocked_o;
    next_customer = customer_unlocked_o;
    next_rp_n = rp_n_o;
    cyc_write = 1'b1;
    cyc_addr = addr;
    cyc_data = data;
    // one cycle launch per bus state, rearmed on completion
    cyc_start = (state inside {ST_FIRST, ST_SECOND, ST_POLL_CMD, ST_POLL}) && !launched;
    if (cyc_start) begin
      next_launched = 1'b1;
    end
    if (cyc_done) begin
      next_launched = 1'b0;
    end
    unique case (state)
      ST_RESET: begin
        if (cnt == CNT_W'(RESET_LOW_CYC - 1)) begin
          next_cnt = '0;
          next_rp_n = 1'b1;
          next_state = ST_WAKE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_WAKE: begin
        if (cnt == CNT_W'(WAKE_CYC - 1)) begin
          next_ready = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      ST_IDLE: begin
        if (req_i) begin
          next_op = op_i;
          next_addr = addr_i;
          next_data = data_i;
          next_cmd = cmd_i;
          next_ready = 1'b0;
          next_refused = 1'b0;
          if (is_modify(op_i) && !supply_ok) begin
            next_refused = 1'b1;
            next_state = ST_FINISH;
          end else begin
            next_state = ST_FIRST;
          end
        end
      end
      ST_FIRST: begin
        cyc_data = {8'h00, first_code(op, cmd)};
        if (cyc_done) begin
          next_state = (op inside {OP_READ_ARRAY, OP_CLEAR_STATUS}) ? ST_FINISH : ST_SECOND;
        end
      end
      ST_SECOND: begin
        cyc_write = is_modify(op);
        unique case (op)
          OP_OTP_LOCK: begin
            cyc_addr = OTP_LOCK_INFO_OFS;
            cyc_data = OTP_LOCK_DATA;
          end
          OP_BLOCK_ERASE: cyc_data = {8'h00, CMD_ERASE_CONFIRM};
          OP_READ_BLOCK_LOCK: cyc_addr = block_lock_addr(addr);
          default: cyc_addr = addr;
        endcase
        if (cyc_done) begin
          if (!is_modify(op)) begin
            next_result = cyc_rdata;
            next_state = ST_FINISH;
            if (op == OP_READ_STATUS) begin
              next_status = cyc_rdata[7:0];
            end
            if (op == OP_READ_ID && addr == OTP_LOCK_INFO_OFS) begin
              next_factory = cyc_rdata[FACTORY_LOCK_BIT];
              next_customer = cyc_rdata[CUSTOMER_LOCK_BIT];
            end
          end else begin
            next_state = ST_POLL_CMD;
          end
        end
      end
      ST_POLL_CMD: begin
        cyc_data = {8'h00, CMD_READ_STATUS};
        if (cyc_done) begin
          next_state = ST_POLL;
        end
      end
      ST_POLL: begin
        cyc_write = 1'b0;
        if (cyc_done) begin
          next_status = cyc_rdata[7:0];
          next_result = cyc_rdata;
          if (cyc_rdata[SR_READY_BIT]) begin
            next_state = ST_FINISH;
          end
        end
      end
      ST_FINISH: begin
        next_done = 1'b1;
        next_ready = 1'b1;
        if (is_modify(op) && !refused_o) begin
          next_prog_fail = status_o[SR_PROG_FAIL_BIT];
          next_protect = status_o[SR_PROTECT_BIT];
        end
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_RESET;
      op <= OP_READ_ARRAY;
      cnt <= '0;
      addr <= '0;
      data <= '0;
      cmd <= '0;
      launched <= 1'b0;
      ready_o <= 1'b0;
      done_o <= 1'b0;
      refused_o <= 1'b0;
      result_o <= '0;
      status_o <= STATUS_RESET; // device leaves reset with 80H
      prog_fail_o <= 1'b0;
      protect_o <= 1'b0;
      factory_unlocked_o <= 1'b0;
      customer_unlocked_o <= 1'b1;
      rp_n_o <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      addr <= next_addr;
      data <= next_data;
      cmd <= next_cmd;
      launched <= next_launched;
      ready_o <= next_ready;
      done_o <= next_done;
      refused_o <= next_refused;
      result_o <= next_result;
      status_o <= next_status;
      prog_fail_o <= next_prog_fail;
      protect_o <= next_protect;
      factory_unlocked_o <= next_factory;
      customer_unlocked_o <= next_customer;
      rp_n_o <= next_rp_n;
    end
  end

  // ========================================================================
  // sequence checks
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_code <= 8'h00;
    end else if (cyc_start && cyc_write) begin
      last_code <= cyc_data[7:0];
    end
  end

  otp_prefix_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == ST_SECOND && cyc_start && op inside {OP_OTP_PROGRAM, OP_OTP_LOCK})
    |-> last_code == CMD_OTP_PROGRAM && cyc_write) else $error("otp write without prefix");
  // lock word is checked on the pins in the cycle after the capturing strobe edge
  lock_word_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == ST_SECOND && op == OP_OTP_LOCK && $rose(we_n_o))
    |-> addr_o == OTP_LOCK_INFO_OFS && dq_o == OTP_LOCK_DATA) else $error("bad lock word");
  id_prefix_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == ST_SECOND && cyc_start && op inside {OP_READ_ID, OP_READ_BLOCK_LOCK})
    |-> last_code == CMD_READ_ID && !cyc_write) else $error("identifier read without 90H");
  block_lock_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == ST_SECOND && cyc_start && op == OP_READ_BLOCK_LOCK)
    |-> cyc_addr[11:0] == 12'h002) else $error("block lock address wrong");
  exact_addr_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == ST_SECOND && op inside {OP_WORD_WRITE, OP_BLOCK_ERASE, OP_TWO_CYCLE}
     && $rose(we_n_o))
    |-> addr_o == addr) else $error("target address altered");
  supply_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == ST_IDLE && req_i && is_modify(op_i) && !supply_ok)
    |=> state == ST_FINISH ##1 (done_o && refused_o && ce_n_o)) else $error("not refused");

endmodule // fiocp_host

// >>> design/fiocp_pkg.sv
// constants, op codes and types of the flash identifier and otp command port host
// ==========================================================================
// Behaviour
// - otp reads start with 90H and last until FFH is written
// - otp program is C0H then a second write of address and data
// - otp lock is C0H then FFFDH written to otp word 80H
// - block erase carries an address inside the block to erase
// - word write carries the exact target address and its data
// - block lock set needs a block address, others any address
// - output enable and write strobe are never low together
package fiocp_pkg;

  // ========================================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RESET_LOW_NS = 100;
  localparam int T_WAKE_NS = 1000;
  localparam int T_WE_PULSE_NS = 50;
  localparam int T_ACCESS_NS = 90;
  localparam int RESET_LOW_CYC = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_PULSE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 2;
  localparam int CNT_W = 8;

  // ========================================================================
  // widths
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // ========================================================================
  // command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_OTP_PROGRAM = 8'hC0;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_WORD_WRITE = 8'h40;

  // ========================================================================
  // device word map in identifier mode
  localparam logic [18:0] MAKER_IDENTITY_OFS = 19'h00000;
  localparam logic [18:0] PART_IDENTITY_OFS = 19'h00001;
  localparam logic [18:0] FIRST_BOOT_BLOCK_LOCK_OFS = 19'h00002;
  localparam logic [18:0] PERMANENT_LOCK_OFS = 19'h00003;
  localparam logic [18:0] OTP_LOCK_INFO_OFS = 19'h00080;
  localparam logic [18:0] BLOCK_LOCK_DISP = 19'h00002;
  localparam logic [15:0] OTP_LOCK_DATA = 16'hFFFD;
  localparam int FACTORY_LOCK_BIT = 0;
  localparam int CUSTOMER_LOCK_BIT = 1;

  // ========================================================================
  // status word
  localparam int SR_READY_BIT = 7;
  localparam int SR_PROG_FAIL_BIT = 4;
  localparam int SR_PROTECT_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h80;

  // ========================================================================
  // user operations
  typedef enum logic [3:0] {
    OP_READ_ARRAY,
    OP_READ_ID,
    OP_READ_BLOCK_LOCK,
    OP_READ_STATUS,
    OP_CLEAR_STATUS,
    OP_OTP_PROGRAM,
    OP_OTP_LOCK,
    OP_WORD_WRITE,
    OP_BLOCK_ERASE,
    OP_TWO_CYCLE
  } fiocp_op_t;

endpackage

// >>> testbench/fiocp_flash_model.sv
// behavioural flash device on the far side of the host pins
`timescale 1ns/100ps
module fiocp_flash_model #(
  parameter int BUSY_NS = 300,
  parameter logic [15:0] MAKER_CODE = 16'h5A01, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h3C02, // arbitrary value
  parameter logic [15:0] PERM_CODE = 16'h0001
) (
  input wire logic rp_n_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic supply_ok_i,
  input wire logic [18:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic fault_o,
  output int wr_cnt_o
);
  logic [1:0] mode;
  logic [7:0] pend;
  logic [7:0] status_word;
  logic [15:0] otp [0:127];
  logic [15:0] rd;
  logic [15:0] last;
  logic lk;
  wire wr_act = ~we_n_i & ~ce_n_i & rp_n_i;
  wire blk_base = (addr_i < 19'h08000) ? (addr_i[11:0] == 12'h002) : (addr_i[14:0] == 15'h0002);
  // ==========================================================================
  // power up: factory area locked, customer area open
  initial begin
    mode = 2'd0;
    pend = 8'h00;
    status_word = 8'h80;
    fault_o = 1'b0;
    wr_cnt_o = 0;
    last = 16'h0000;
    for (int i = 0; i < 128; i++) begin
      otp[i] = 16'hFFFF;
    end
    otp[0] = 16'hFFFE;
  end
  // reset mode returns read array and status 80H
  always @(negedge rp_n_i) begin
    mode = 2'd0;
    pend = 8'h00;
    status_word = 8'h80;
  end
  // write state machine turns ready after a fixed busy time
  always @(negedge status_word[7]) begin
    #(BUSY_NS) status_word[7] = 1'b1;
  end
  // address and data taken when strobe or select rises first
  always @(negedge wr_act) begin
    wr_cnt_o = wr_cnt_o + 1;
    if (pend != 8'h00) begin
      if (supply_ok_i) begin
        status_word[7] = 1'b0;
      end
      if (supply_ok_i && pend == 8'hC0) begin
        lk = (addr_i[6:0] < 7'h05) ? ~otp[0][0] : ~otp[0][1];
        if (addr_i[6:0] == 7'h00) begin
          otp[0] = otp[0] & dq_i;
        end else if (lk) begin
          status_word[4] = 1'b1;
          status_word[1] = 1'b1;
        end else begin
          otp[addr_i[6:0]] = otp[addr_i[6:0]] & dq_i;
        end
      end
      // erase and word write never touch the otp words
      pend = 8'h00;
      mode = 2'd2;
    end else begin
      case (dq_i[7:0])
        8'hFF: mode = 2'd0;
        8'h90: mode = 2'd1;
        8'h70: mode = 2'd2;
        8'h50: status_word[5:1] = 5'h00;
        default: pend = dq_i[7:0];
      endcase
    end
  end
  // read word of the selected mode
  always_comb begin
    rd = addr_i[15:0] ^ 16'hA5A5;
    if (mode == 2'd2) begin
      rd = {8'h00, status_word};
    end else if (mode == 2'd1) begin
      rd = 16'h0000;
      if (addr_i == 19'h00000) rd = MAKER_CODE;
      else if (addr_i == 19'h00001) rd = PART_CODE;
      else if (addr_i == 19'h00003) rd = PERM_CODE;
      else if (addr_i[18:7] == 12'h001) rd = otp[addr_i[6:0]];
      else if (blk_base) rd = {addr_i[18:12], 9'h000};
    end
  end
  // released lines show the inverse of the last word
  always @(posedge oe_n_i) last = rd;
  assign dq_o = (rp_n_i & ~ce_n_i & ~oe_n_i) ? rd : ~last;
  // output enable and strobe low together is a host fault
  always @(negedge oe_n_i or negedge we_n_i) begin
    if (!oe_n_i && !we_n_i) fault_o = 1'b1;
  end
endmodule // fiocp_flash_model

// >>> testbench/fiocp_host_bench.sv
// self-checking bench of the flash identifier and otp host
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module fiocp_host_bench;
  import fiocp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic supply = 1'b1;
  logic [7:0] cmd = 8'h00;
  fiocp_op_t op = OP_READ_ARRAY;
  logic [18:0] addr = 19'h00000;
  logic [15:0] data = 16'h0000;
  logic ready, done, refused, prog_fail, protect, fac_unl, cus_unl, rp_n, ce_n, we_n, oe_n, fault;
  logic [7:0] status;
  logic [18:0] pin_addr;
  logic [15:0] result, dq_o, dq_oe, mdl_q, dq_bus;
  int wr_cnt;
  int failures = 0;
  int check_count = 0;
  // ==========================================================================
  // wire level of the shared data lines
  assign dq_bus = (dq_oe & dq_o) | (~dq_oe & mdl_q);
  always #5 clk = ~clk;
  fiocp_host i_dut (
    .core_clk_i(clk), .rst_i(rst), .req_i(req), .op_i(op), .addr_i(addr), .data_i(data),
    .cmd_i(cmd), .supply_ok_i(supply), .ready_o(ready), .done_o(done), .refused_o(refused),
    .result_o(result), .status_o(status), .prog_fail_o(prog_fail), .protect_o(protect),
    .factory_unlocked_o(fac_unl), .customer_unlocked_o(cus_unl), .rp_n_o(rp_n),
    .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(pin_addr), .dq_o(dq_o),
    .dq_oe_o(dq_oe), .dq_i(dq_bus));
  fiocp_flash_model i_flash (
    .rp_n_i(rp_n), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .supply_ok_i(supply),
    .addr_i(pin_addr), .dq_i(dq_bus), .dq_o(mdl_q), .fault_o(fault), .wr_cnt_o(wr_cnt));
  // ==========================================================================
  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one user operation, waits for the done pulse under a bound
  task automatic run_op(input fiocp_op_t o, input logic [18:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    op = o;
    addr = a;
    data = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    while (done !== 1'b1) begin
      n++;
      if (n > 20000) begin
        failures++;
        $display("[ERR] %0t operation timed out", $time);
        report_and_stop();
      end
      @(negedge clk);
    end
  endtask
  // identifier read with expected word
  task automatic read_id(input logic [18:0] a, input logic [15:0] e);
    run_op(OP_READ_ID, a, 16'h0000);
    `CHK(result, e)
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    int n;
    n = 0;
    while (ready !== 1'b1) begin
      n++;
      if (n > 500) begin
        failures++;
        $display("[ERR] %0t ready never rose", $time);
        report_and_stop();
      end
      @(negedge clk);
    end
    `CHK(status, 8'h80)
    `CHK(cus_unl, 1'b1)
    `CHK(rp_n, 1'b1)
    run_op(OP_READ_STATUS, 19'h00000, 16'h0000);
    `CHK(result[7:0], 8'h80)
    $display("test reset done");
  endtask
  task automatic t_ident();
    read_id(19'h00000, 16'h5A01);
    read_id(19'h00001, 16'h3C02);
    read_id(19'h00003, 16'h0001);
    run_op(OP_READ_BLOCK_LOCK, 19'h2ABCD, 16'h0000);
    `CHK(result, 16'h5000)
    run_op(OP_READ_BLOCK_LOCK, 19'h03456, 16'h0000);
    `CHK(result, 16'h0600)
    read_id(19'h00080, 16'hFFFE);
    `CHK(fac_unl, 1'b0)
    `CHK(cus_unl, 1'b1)
    $display("test ident done");
  endtask
  task automatic t_otp();
    run_op(OP_OTP_PROGRAM, 19'h00085, 16'h1234);
    `CHK(prog_fail, 1'b0)
    read_id(19'h00085, 16'h1234);
    run_op(OP_OTP_PROGRAM, 19'h00081, 16'h0000);
    `CHK(prog_fail, 1'b1)
    `CHK(protect, 1'b1)
    `CHK(status, 8'h92)
    read_id(19'h00081, 16'hFFFF);
    run_op(OP_CLEAR_STATUS, 19'h00000, 16'h0000);
    run_op(OP_READ_STATUS, 19'h00000, 16'h0000);
    `CHK(result[7:0], 8'h80)
    $display("test otp done");
  endtask
  task automatic t_lock();
    run_op(OP_OTP_LOCK, 19'h00080, 16'hFFFD);
    read_id(19'h00080, 16'hFFFC);
    `CHK(cus_unl, 1'b0)
    run_op(OP_OTP_PROGRAM, 19'h00086, 16'h5555);
    `CHK(prog_fail, 1'b1)
    read_id(19'h00086, 16'hFFFF);
    run_op(OP_OTP_PROGRAM, 19'h00080, 16'hFFFF);
    read_id(19'h00080, 16'hFFFC);
    $display("test lock done");
  endtask
  task automatic t_refuse();
    int n;
    supply = 1'b0;
    repeat (4) @(negedge clk);
    n = wr_cnt;
    run_op(OP_OTP_PROGRAM, 19'h00087, 16'h0000);
    `CHK(refused, 1'b1)
    `CHK(wr_cnt, n)
    read_id(19'h00087, 16'hFFFF);
    supply = 1'b1;
    repeat (4) @(negedge clk);
    $display("test refuse done");
  endtask
  task automatic t_erase();
    int n;
    run_op(OP_READ_ARRAY, 19'h00000, 16'h0000);
    run_op(OP_BLOCK_ERASE, 19'h00000, 16'h0000);
    `CHK(refused, 1'b0)
    run_op(OP_WORD_WRITE, 19'h12345, 16'hBEEF);
    `CHK(refused, 1'b0)
    // lock-bit style command: code, data write at the block, status command
    cmd = 8'h60;
    n = wr_cnt;
    run_op(OP_TWO_CYCLE, 19'h28000, 16'h0001);
    `CHK(wr_cnt, n + 3)
    read_id(19'h00085, 16'h1234);
    `CHK(fault, 1'b0)
    $display("test erase done");
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_ident();
    t_otp();
    t_lock();
    t_refuse();
    t_erase();
    report_and_stop();
  end
endmodule // fiocp_host_bench
